// ---- src/pss_status_regs.sv ----
// PHY status registers and clause-45 address/data window behind AXI4-Lite.
// Assumes status inputs come from the line-side core, asynchronous to aclk.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
module pss_status_regs (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write
   input  wire logic [pss_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic      [1:0]                 s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // AXI4-Lite read
   input  wire logic [pss_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic      [31:0]                s_axi_rdata,
   output logic      [1:0]                 s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Gigabit resolution and receiver state
   input  wire logic                       ms_resolved,
   input  wire logic                       ms_master,
   input  wire logic                       ms_cfg_fault,
   input  wire logic                       loc_rx_ok,
   input  wire logic                       rem_rx_ok,
   input  wire logic                       link_partner_1g_fdx,
   input  wire logic                       link_partner_1g_hdx,
   input  wire logic                       idle_err,
   // Fast Ethernet receive path
   input  wire logic                       fe_lock,
   input  wire logic                       fe_link,
   input  wire logic                       fe_lock_err,
   input  wire logic                       fe_disconnect,
   input  wire logic                       fe_rx_err,
   input  wire logic                       fe_tx_err,
   input  wire logic                       fe_start_delimiter_err,
   input  wire logic                       fe_end_delimiter_err,
   // Gigabit receive path
   input  wire logic                       ge_lock,
   input  wire logic                       ge_link,
   input  wire logic                       ge_lock_err,
   input  wire logic                       ge_disconnect,
   input  wire logic                       ge_rx_err,
   input  wire logic                       ge_tx_err,
   input  wire logic                       ge_start_delimiter_err,
   input  wire logic                       ge_end_delimiter_err,
   input  wire logic                       ge_carrier_ext_err,
   input  wire logic                       legacy_link_partner,
   input  wire logic                       mdi_crossover_err
);

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; events are taken on the rising edge of their level

   logic [10:0] lv_s1_r;
   logic [10:0] lv_s2_r;
   logic [15:0] ev_s1_r;
   logic [15:0] ev_s2_r;
   logic [15:0] ev_s3_r;

   wire [10:0] lv_raw = {ms_master, loc_rx_ok, rem_rx_ok, link_partner_1g_fdx,
                         link_partner_1g_hdx, fe_lock, fe_link, ge_lock, ge_link,
                         legacy_link_partner, mdi_crossover_err};
   wire [15:0] ev_raw = {ms_resolved, ms_cfg_fault, idle_err, fe_lock_err,
                         fe_disconnect, fe_rx_err, fe_tx_err, fe_start_delimiter_err,
                         fe_end_delimiter_err, ge_lock_err, ge_disconnect, ge_rx_err,
                         ge_tx_err, ge_start_delimiter_err, ge_end_delimiter_err,
                         ge_carrier_ext_err};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lv_s1_r <= 11'h000;
         lv_s2_r <= 11'h000;
         ev_s1_r <= 16'h0000;
         ev_s2_r <= 16'h0000;
         ev_s3_r <= 16'h0000;
      end
      else
      begin
         lv_s1_r <= lv_raw;
         lv_s2_r <= lv_s1_r;
         ev_s1_r <= ev_raw;
         ev_s2_r <= ev_s1_r;
         ev_s3_r <= ev_s2_r;
      end
   end

   wire [15:0] ev_p      = ev_s2_r & ~ev_s3_r;
   wire        resolve_p = ev_p[15];
   wire        fault_p   = ev_p[14];
   wire        idle_p    = ev_p[13];
   wire [5:0]  fe_set    = ev_p[12:7];
   wire [6:0]  ge_set    = ev_p[6:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake; one access at a time so the window address never races

   logic                 aw_ready_r;
   logic                 ar_ready_r;
   logic                 rd_stage_r;
   logic                 bvalid_r;
   logic                 rvalid_r;
   logic [1:0]           bresp_r;
   logic [1:0]           rresp_r;
   logic [31:0]          rdata_r;
   logic [5:0]           rd_idx_r;
   logic [15:0]          rd_word;

   wire       ar_start = s_axi_arvalid && !ar_ready_r && !rd_stage_r && !rvalid_r &&
                         !aw_ready_r;
   wire       wr_start = s_axi_awvalid && s_axi_wvalid && !aw_ready_r && !bvalid_r &&
                         !ar_ready_r && !rd_stage_r && !ar_start;
   wire       ar_hs    = ar_ready_r && s_axi_arvalid;
   wire       wcommit  = aw_ready_r && s_axi_awvalid && s_axi_wvalid;
   wire [5:0] widx     = pss_pkg::reg_idx(s_axi_awaddr);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ready_r <= 1'b0;
         ar_ready_r <= 1'b0;
         rd_stage_r <= 1'b0;
         bvalid_r   <= 1'b0;
         rvalid_r   <= 1'b0;
         bresp_r    <= pss_pkg::RESP_OKAY;
         rresp_r    <= pss_pkg::RESP_OKAY;
         rdata_r    <= 32'h0000_0000;
         rd_idx_r   <= 6'h00;
      end
      else
      begin
         aw_ready_r <= wr_start;
         ar_ready_r <= ar_start;
         rd_stage_r <= ar_hs;
         if (wcommit)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= pss_pkg::is_mapped(widx) ? pss_pkg::RESP_OKAY : pss_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
         if (ar_hs)
         begin
            rd_idx_r <= pss_pkg::reg_idx(s_axi_araddr);
         end
         if (rd_stage_r)
         begin
            rvalid_r <= 1'b1;
            rdata_r  <= {16'h0000, rd_word};
            rresp_r  <= pss_pkg::is_mapped(rd_idx_r) ? pss_pkg::RESP_OKAY
                                                      : pss_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_awready = aw_ready_r;
   assign s_axi_wready  = aw_ready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = ar_ready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Clause-45 access control and window

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   logic [15:0]          ctrl_r;
   logic [15:0]          c45_addr_r;
   logic [15:0]          c45_addr_nxt;
   logic [15:0]          mem_q;

   wire pss_pkg::pss_fn_t func  = pss_pkg::pss_fn_t'(ctrl_r[15:14]);
   wire [4:0]            dev    = ctrl_r[4:0];
   wire                  win_wr = wcommit && (widx == pss_pkg::IDX_WIN);
   wire                  win_rd = rd_stage_r && (rd_idx_r == pss_pkg::IDX_WIN);
   wire                  is_adr = (func == pss_pkg::FN_ADDR);
   wire                  inc_wr = win_wr && ((func == pss_pkg::FN_DATA_INC_RW) ||
                                             (func == pss_pkg::FN_DATA_INC_W));
   wire                  inc_rd = win_rd && (func == pss_pkg::FN_DATA_INC_RW);
   wire                  mem_we = win_wr && !is_adr;
   wire [pss_pkg::MEM_AW-1:0] mem_addr = {dev[pss_pkg::DEV_KEEP-1:0],
                                          c45_addr_r[pss_pkg::REG_KEEP-1:0]};

   // Function 01 falls through with the address left alone
   assign c45_addr_nxt = (win_wr && is_adr) ? merge(c45_addr_r, s_axi_wdata, s_axi_wstrb)
                       : inc_wr ? c45_addr_r + 16'h0001
                       : inc_rd ? c45_addr_r + 16'h0001
                       : c45_addr_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r     <= pss_pkg::RST_CTRL;
         c45_addr_r <= pss_pkg::RST_ADDR;
      end
      else
      begin
         if (wcommit && (widx == pss_pkg::IDX_CTRL))
         begin
            ctrl_r <= merge(ctrl_r, s_axi_wdata, s_axi_wstrb);
         end
         c45_addr_r <= c45_addr_nxt;
      end
   end

   // Partial strobes keep the untouched byte of the addressed word
   pss_c45_mem u_mem (
      .aclk  (aclk),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (merge(mem_q, s_axi_wdata, s_axi_wstrb)),
      .rdata (mem_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags; a new event in the read cycle survives the clear

   logic                 fault_r;
   logic                 master_r;
   logic [7:0]           idle_cnt_r;
   logic [5:0]           fe_flags_r;
   logic [6:0]           ge_flags_r;

   wire       clr_gls  = rd_stage_r && (rd_idx_r == pss_pkg::IDX_GLS);
   wire       clr_fe   = rd_stage_r && (rd_idx_r == pss_pkg::IDX_FE);
   wire       clr_ge   = rd_stage_r && (rd_idx_r == pss_pkg::IDX_GE);
   wire [7:0] idle_bas = clr_gls ? 8'h00 : idle_cnt_r;
   wire [7:0] idle_nxt = (idle_p && (idle_bas != pss_pkg::IDLE_MAX)) ? idle_bas + 8'h01
                                                                     : idle_bas;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fault_r    <= 1'b0;
         master_r   <= pss_pkg::RST_MASTER;
         idle_cnt_r <= 8'h00;
         fe_flags_r <= 6'h00;
         ge_flags_r <= 7'h00;
      end
      else
      begin
         fault_r    <= (fault_r && !clr_gls) || fault_p;
         idle_cnt_r <= idle_nxt;
         fe_flags_r <= (fe_flags_r & {6{!clr_fe}}) | fe_set;
         ge_flags_r <= (ge_flags_r & {7{!clr_ge}}) | ge_set;
         // Only the resolution moment is captured; later role swaps are ignored
         if (resolve_p)
         begin
            master_r <= lv_s2_r[10];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data selection

   wire [15:0] gls_word = {fault_r, master_r, lv_s2_r[9], lv_s2_r[8],
                           lv_s2_r[7], lv_s2_r[6], 2'b00, idle_cnt_r};
   wire [15:0] fe_word  = {lv_s2_r[5], fe_flags_r[5:4], lv_s2_r[4],
                           fe_flags_r[3:0], 8'h00};
   wire [15:0] ge_word  = {lv_s2_r[3], ge_flags_r[6:5], lv_s2_r[2],
                           ge_flags_r[4:0], lv_s2_r[1], lv_s2_r[0], 5'h00};
   wire [15:0] win_word = is_adr ? c45_addr_r : mem_q;

   assign rd_word = (rd_idx_r == pss_pkg::IDX_GLS)  ? gls_word
                  : (rd_idx_r == pss_pkg::IDX_CTRL) ? ctrl_r
                  : (rd_idx_r == pss_pkg::IDX_WIN)  ? win_word
                  : (rd_idx_r == pss_pkg::IDX_ABIL) ? pss_pkg::ABIL_VALUE
                  : (rd_idx_r == pss_pkg::IDX_FE)   ? fe_word
                  : (rd_idx_r == pss_pkg::IDX_GE)   ? ge_word
                  : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence rd_of(logic [5:0] i);
      rd_stage_r && (rd_idx_r == i);
   endsequence

   chk_fault_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      fault_r && !clr_gls |=> fault_r)
      else $error("fault flag dropped without a read");

   chk_master_stable: assert property (@(posedge aclk) disable iff (!aresetn)
      !resolve_p |=> $stable(master_r))
      else $error("resolution bit changed without a resolution");

   chk_ability_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_of(pss_pkg::IDX_ABIL) |=> rdata_r == 32'h0000_3000)
      else $error("ability register wrong");

   chk_fe_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_of(pss_pkg::IDX_FE) ##0 (fe_set == 6'h00) |=> fe_flags_r == 6'h00)
      else $error("fast status flags not cleared by read");

   chk_idle_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_of(pss_pkg::IDX_GLS) ##0 !idle_p |=> idle_cnt_r == 8'h00)
      else $error("idle count not cleared by read");

   chk_inc_both: assert property (@(posedge aclk) disable iff (!aresetn)
      win_rd && (func == pss_pkg::FN_DATA_INC_RW) |=> c45_addr_r == $past(c45_addr_r) + 16'h0001)
      else $error("window address not advanced after read");

   chk_inc_wr_only: assert property (@(posedge aclk) disable iff (!aresetn)
      win_rd && (func == pss_pkg::FN_DATA_INC_W) |=> $stable(c45_addr_r))
      else $error("window address moved on read");

   chk_addr_load: assert property (@(posedge aclk) disable iff (!aresetn)
      win_wr && is_adr && (s_axi_wstrb[1:0] == 2'b11) |=> c45_addr_r == $past(s_axi_wdata[15:0]))
      else $error("window address not loaded");

   chk_live_lock: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_of(pss_pkg::IDX_GE) |=> rdata_r[15] == $past(lv_s2_r[3]))
      else $error("gigabit lock bit not live");

   chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs |-> ##2 rvalid_r)
      else $error("read answer late");

endmodule : pss_status_regs

// ---- src/pss_pkg.sv ----
// Package for the PHY status and clause-45 window register bank.
// Assumes a 32-bit AXI4-Lite slave port on a single 25 MHz clock.
package pss_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry and answers
   localparam int         ADDR_W      = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_GLS  = 6'h0A;
   localparam logic [5:0] IDX_CTRL = 6'h0D;
   localparam logic [5:0] IDX_WIN  = 6'h0E;
   localparam logic [5:0] IDX_ABIL = 6'h0F;
   localparam logic [5:0] IDX_FE   = 6'h10;
   localparam logic [5:0] IDX_GE   = 6'h11;

   ////////////////////////////////////////////////////////////////////////////////
   // Values after reset and fixed contents
   localparam logic        RST_MASTER  = 1'h1;
   localparam logic [15:0] RST_CTRL    = 16'h0000;
   localparam logic [15:0] RST_ADDR    = 16'h0000;
   localparam logic [15:0] ABIL_VALUE  = 16'h3000;
   localparam logic [7:0]  IDLE_MAX    = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////////
   // Clause-45 store: low device bits and low register bits form the index
   localparam int DEV_KEEP = 3;
   localparam int REG_KEEP = 5;
   localparam int MEM_AW   = DEV_KEEP + REG_KEEP;

   typedef enum logic [1:0] {
      FN_ADDR,
      FN_DATA,
      FN_DATA_INC_RW,
      FN_DATA_INC_W
   } pss_fn_t;

   function automatic logic [5:0] reg_idx(input logic [ADDR_W-1:0] a);
      return a[7:2];
   endfunction : reg_idx

   function automatic logic is_mapped(input logic [5:0] i);
      return (i == IDX_GLS) || (i == IDX_CTRL) || (i == IDX_WIN) ||
             (i == IDX_ABIL) || (i == IDX_FE) || (i == IDX_GE);
   endfunction : is_mapped

endpackage : pss_pkg

// ---- src/pss_c45_mem.sv ----
// Small store behind the clause-45 window, one 16-bit word per entry.
// Assumes one write port and a registered read of the same address.
`timescale 1ns/1ns
module pss_c45_mem (
   // Clock
   input  wire logic                      aclk,
   // Access
   input  wire logic                      we,
   input  wire logic [pss_pkg::MEM_AW-1:0] addr,
   input  wire logic [15:0]               wdata,
   output logic      [15:0]               rdata
);

   logic [15:0] mem [0:(1<<pss_pkg::MEM_AW)-1];

   // No reset: contents are undefined until software writes them
   always_ff @(posedge aclk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule : pss_c45_mem

// ---- bench/pss_line_partner.sv ----
// Behavioural line-side link partner for the status register bank.
// Assumes the bench commands it by non-blocking writes on rising aclk.
`timescale 1ns/1ns
module pss_line_partner (
   // Clock
   input  wire logic        aclk,
   // Commands from the bench
   input  wire logic [10:0] live_set,
   input  wire logic [15:0] evt_fire,
   // Line-side conditions
   output logic      [10:0] live_o,
   output logic      [15:0] evt_o
);
   ////////////////////////////////////////
   logic [15:0] stg0_r = 16'h0000;
   logic [15:0] stg1_r = 16'h0000;
   logic [15:0] stg2_r = 16'h0000;

   // Events stand three cycles so a two-flop synchroniser cannot miss them
   assign evt_o  = stg0_r | stg1_r | stg2_r;
   assign live_o = live_set;

   always_ff @(posedge aclk)
   begin
      stg0_r <= evt_fire;
      stg1_r <= stg0_r;
      stg2_r <= stg1_r;
   end
endmodule : pss_line_partner

// ---- bench/phy_status_mmd_window_regs_test.sv ----
// Self-checking bench for the PHY status and clause-45 window registers.
// Assumes the line partner model drives every status input.
`timescale 1ns/1ns
`define CHK(g, e) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("wrong value t=%0t got %h exp %h", $time, g, e); \
      end \
   end
module phy_status_mmd_window_regs_test;
   ////////////////////////////////////////
   localparam logic [1:0] OK = pss_pkg::RESP_OKAY;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic        awready;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  wstrb = 4'hF;
   logic        wvalid = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready = 1'b0;
   logic [10:0] live_set = 11'h000;
   logic [15:0] evt_fire = 16'h0000;
   logic [10:0] lv;
   logic [15:0] ev;
   int          fails = 0;
   int          total_checks = 0;

   always #20 aclk = ~aclk;

   pss_line_partner u_line (.aclk(aclk), .live_set(live_set), .evt_fire(evt_fire),
      .live_o(lv), .evt_o(ev));

   pss_status_regs uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ms_master(lv[0]), .loc_rx_ok(lv[1]), .rem_rx_ok(lv[2]),
      .link_partner_1g_fdx(lv[3]), .link_partner_1g_hdx(lv[4]),
      .fe_lock(lv[5]), .fe_link(lv[6]), .ge_lock(lv[7]), .ge_link(lv[8]),
      .legacy_link_partner(lv[9]), .mdi_crossover_err(lv[10]),
      .ms_resolved(ev[0]), .ms_cfg_fault(ev[1]), .idle_err(ev[2]),
      .fe_lock_err(ev[3]), .fe_disconnect(ev[4]), .fe_rx_err(ev[5]), .fe_tx_err(ev[6]),
      .fe_start_delimiter_err(ev[7]), .fe_end_delimiter_err(ev[8]),
      .ge_lock_err(ev[9]), .ge_disconnect(ev[10]), .ge_rx_err(ev[11]), .ge_tx_err(ev[12]),
      .ge_start_delimiter_err(ev[13]), .ge_end_delimiter_err(ev[14]),
      .ge_carrier_ext_err(ev[15]));

   ////////////////////////////////////////
   // Bus tasks; each opens on a fresh edge so no signal is driven twice in one step
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata[15:0];
      r = rresp;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      `CHK(r, OK)
      `CHK(d, e)
   endtask : rc

   task automatic live(input logic [10:0] m);
      @(posedge aclk);
      live_set <= m;
      repeat (6) @(posedge aclk);
   endtask : live

   task automatic fire(input logic [15:0] m);
      @(posedge aclk);
      evt_fire <= m;
      @(posedge aclk);
      evt_fire <= 16'h0000;
      repeat (8) @(posedge aclk);
   endtask : fire

   // Address phase first, then the data function code
   task automatic seta(input logic [1:0] f, input logic [4:0] dv, input logic [15:0] a);
      wr(8'h34, {11'h000, dv}, OK);
      wr(8'h38, a, OK);
      wr(8'h34, {f, 9'h000, dv}, OK);
   endtask : seta

   ////////////////////////////////////////
   task automatic t_regs;
      logic [15:0] d;
      logic [1:0]  r;
      rc(8'h28, 16'h4000);
      rc(8'h3C, 16'h3000);
      rc(8'h40, 16'h0000);
      rc(8'h44, 16'h0000);
      rc(8'h34, 16'h0000);
      wr(8'h3C, 16'hFFFF, OK);
      rc(8'h3C, 16'h3000);
      wr(8'h04, 16'h1234, pss_pkg::RESP_SLVERR);
      rd(8'h04, d, r);
      `CHK(r, pss_pkg::RESP_SLVERR)
      `CHK(d, 16'h0000)
   endtask : t_regs

   task automatic t_live;
      live(11'h7FF);
      rc(8'h28, 16'h7C00);
      rc(8'h40, 16'h9000);
      rc(8'h44, 16'h9060);
      // Alternating patterns catch neighbouring bits that are swapped
      live(11'h2AA);
      rc(8'h28, 16'h6800);
      rc(8'h40, 16'h8000);
      rc(8'h44, 16'h8040);
      live(11'h554);
      rc(8'h28, 16'h5400);
      rc(8'h40, 16'h1000);
      rc(8'h44, 16'h1020);
      live(11'h000);
      rc(8'h28, 16'h4000);
      rc(8'h40, 16'h0000);
      rc(8'h44, 16'h0000);
   endtask : t_live

   // A later role swap changes the live level only, with no new resolution
   task automatic t_resolve;
      fire(16'h0001);
      rc(8'h28, 16'h0000);
      live(11'h001);
      rc(8'h28, 16'h0000);
      fire(16'h0001);
      rc(8'h28, 16'h4000);
   endtask : t_resolve

   task automatic t_events;
      fire(16'h0006);
      fire(16'h0004);
      fire(16'hFFF8);
      rc(8'h28, 16'hC002);
      rc(8'h28, 16'h4000);
      rc(8'h40, 16'h6F00);
      rc(8'h40, 16'h0000);
      rc(8'h44, 16'h6F80);
      rc(8'h44, 16'h0000);
      // Half the error sources at a time, so each flag lands on its own bit
      fire(16'h5550);
      rc(8'h40, 16'h2500);
      rc(8'h44, 16'h2500);
      fire(16'hAAA8);
      rc(8'h40, 16'h4A00);
      rc(8'h44, 16'h4A80);
   endtask : t_events

   task automatic t_window;
      seta(2'b00, 5'h05, 16'h0003);
      rc(8'h38, 16'h0003);
      seta(2'b01, 5'h05, 16'h0003);
      rc(8'h34, 16'h4005);
      wr(8'h38, 16'hAAAA, OK);
      rc(8'h38, 16'hAAAA);
      rc(8'h38, 16'hAAAA);
      seta(2'b10, 5'h05, 16'h0003);
      wr(8'h38, 16'h1111, OK);
      wr(8'h38, 16'h2222, OK);
      seta(2'b10, 5'h05, 16'h0003);
      rc(8'h38, 16'h1111);
      rc(8'h38, 16'h2222);
      seta(2'b11, 5'h05, 16'h0003);
      rc(8'h38, 16'h1111);
      rc(8'h38, 16'h1111);
      wr(8'h38, 16'h3333, OK);
      rc(8'h38, 16'h2222);
      seta(2'b01, 5'h06, 16'h0003);
      wr(8'h38, 16'h5555, OK);
      rc(8'h38, 16'h5555);
      seta(2'b01, 5'h05, 16'h0003);
      rc(8'h38, 16'h3333);
   endtask : t_window

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_regs();
      t_live();
      t_resolve();
      t_events();
      t_window();
      results();
   end

   // Whole run needs under five hundred cycles; this only cuts a hang short
   initial
   begin
      repeat (20000) @(posedge aclk);
      fails++;
      results();
   end
endmodule : phy_status_mmd_window_regs_test
